// ---- shared/gpc_pkg.sv ----
// Shared constants and types for the configurable port pin control block
package gpc_pkg;
    // Port geometry: three 8-bit ports and one 2-bit port
    localparam int NUM_PORTS = 4;
    localparam int PORT_W    = 8;
    localparam int NUM_PINS  = 26;
    localparam int ADDR_W    = 8;

    // Register map: each port owns a 16-byte slot at port * 16
    localparam logic [3:0] OFS_PIN_LEVEL = 4'h0;
    localparam logic [3:0] OFS_LATCH     = 4'h4;
    localparam logic [3:0] OFS_MODE_LOW  = 4'h8;
    localparam logic [3:0] OFS_MODE_HIGH = 4'hc;
    localparam logic [7:0] ADDR_ANALOG   = 8'h40;

    // Reset values: mode bits 10 put every pin in input-only
    localparam logic [7:0] LATCH_RST     = 8'hff;
    localparam logic [7:0] MODE_LOW_RST  = 8'hff;
    localparam logic [7:0] MODE_HIGH_RST = 8'h00;
    localparam logic [7:0] ANALOG_RST    = 8'h00;
    localparam logic [7:0] ANALOG_MASK   = 8'h3e;
    localparam logic [7:0] PORT3_MASK    = 8'h03;

    // Restricted pins, as flat pin index port * 8 + bit
    localparam int PIN_RESET_INPUT = 13;
    localparam int PIN_CLOCK_LINE  = 10;
    localparam int PIN_DATA_LINE   = 11;

    // Strong pull-up pulse length in CPU clocks
    localparam logic [1:0] STRONG_CYCLES = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin output mode, {mode_low bit, mode_high bit}
    typedef enum logic [1:0] {
        GPC_QUASI      = 2'h0,
        GPC_PUSH_PULL  = 2'h1,
        GPC_INPUT_ONLY = 2'h2,
        GPC_OPEN_DRAIN = 2'h3
    } gpc_mode_e;
endpackage

// ---- hdl/gpc_pin_cell.sv ----
// Driver control for a single port pin
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_cell #(
    parameter bit FORCE_INPUT = 1'b0,
    parameter bit NO_PULLUP   = 1'b0
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       latch_in,
    input  wire logic [1:0] mode_in,
    input  wire logic       pin_sync_in,
    output logic            very_weak_pu_out,
    output logic            weak_pu_out,
    output logic            strong_pu_out,
    output logic            pull_down_out
);
    gpc_pkg::gpc_mode_e eff_mode;
    logic               latch_prev;
    logic               latch_rise;
    logic [1:0]         pulse_cnt;
    logic [1:0]         next_pulse_cnt;

    // Restricted pins fall back to a mode without pull-ups
    always_comb begin
        if (FORCE_INPUT) begin
            eff_mode = gpc_pkg::GPC_INPUT_ONLY;
        end else if (NO_PULLUP && !mode_in[1]) begin
            eff_mode = gpc_pkg::GPC_OPEN_DRAIN;
        end else begin
            eff_mode = gpc_pkg::gpc_mode_e'(mode_in);
        end
    end

    // Previous latch value for rising edge detection
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            latch_prev <= 1'b1;
        end else begin
            latch_prev <= latch_in;
        end
    end

    assign latch_rise = latch_in & ~latch_prev;

    // Strong pull-up countdown; dropping quasi mode or the latch ends it early
    always_comb begin
        if (eff_mode != gpc_pkg::GPC_QUASI || !latch_in) begin
            next_pulse_cnt = 2'h0;
        end else if (latch_rise) begin
            next_pulse_cnt = gpc_pkg::STRONG_CYCLES;
        end else if (pulse_cnt != 2'h0) begin
            next_pulse_cnt = pulse_cnt - 2'h1;
        end else begin
            next_pulse_cnt = 2'h0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pulse_cnt <= 2'h0;
        end else begin
            pulse_cnt <= next_pulse_cnt;
        end
    end

    // Registered drivers; reset leaves the pin floating
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            very_weak_pu_out <= 1'b0;
            weak_pu_out      <= 1'b0;
            strong_pu_out    <= 1'b0;
            pull_down_out    <= 1'b0;
        end else begin
            case (eff_mode)
                gpc_pkg::GPC_QUASI: begin
                    very_weak_pu_out <= latch_in;
                    weak_pu_out      <= latch_in & pin_sync_in;
                    strong_pu_out    <= (next_pulse_cnt != 2'h0);
                    pull_down_out    <= ~latch_in;
                end
                gpc_pkg::GPC_PUSH_PULL: begin
                    very_weak_pu_out <= 1'b0;
                    weak_pu_out      <= 1'b0;
                    strong_pu_out    <= latch_in;
                    pull_down_out    <= ~latch_in;
                end
                gpc_pkg::GPC_OPEN_DRAIN: begin
                    very_weak_pu_out <= 1'b0;
                    weak_pu_out      <= 1'b0;
                    strong_pu_out    <= 1'b0;
                    pull_down_out    <= ~latch_in;
                end
                default: begin
                    very_weak_pu_out <= 1'b0;
                    weak_pu_out      <= 1'b0;
                    strong_pu_out    <= 1'b0;
                    pull_down_out    <= 1'b0;
                end
            endcase
        end
    end

    a_strong_pulse_two: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (eff_mode == gpc_pkg::GPC_QUASI && latch_rise)
            ##1 (eff_mode == gpc_pkg::GPC_QUASI && latch_in)[*2]
        |-> $past(strong_pu_out, 1) && strong_pu_out && !$past(strong_pu_out, 2) ##1 !strong_pu_out
    ) else $error("strong pull-up pulse is not two cycles");

    a_weak_needs_pin: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (eff_mode == gpc_pkg::GPC_QUASI && latch_in && !pin_sync_in)
        |=> !weak_pu_out && very_weak_pu_out
    ) else $error("weak pull-up on while pin is pulled low");

    a_open_drain_pull: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (eff_mode == gpc_pkg::GPC_OPEN_DRAIN)
        |=> !very_weak_pu_out && !weak_pu_out && !strong_pu_out
            && (pull_down_out == !$past(latch_in))
    ) else $error("open-drain pin drives a pull-up or wrong pull-down");

    a_input_floats: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (eff_mode == gpc_pkg::GPC_INPUT_ONLY)[*2]
        |-> !very_weak_pu_out && !weak_pu_out && !strong_pu_out && !pull_down_out
    ) else $error("input-only pin has a driver enabled");

    a_push_pull_drive: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (eff_mode == gpc_pkg::GPC_PUSH_PULL && latch_in)
        |=> strong_pu_out && !pull_down_out
    ) else $error("push-pull pin not driven high");

    a_quasi_low: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (eff_mode == gpc_pkg::GPC_QUASI && !latch_in)
        |=> pull_down_out && !very_weak_pu_out && !strong_pu_out
    ) else $error("quasi pin with latch 0 not pulled down");
endmodule
`default_nettype wire

// ---- hdl/gpc_port_ctrl.sv ----
// Top of the port pin control block: AXI4-Lite registers, pin synchronisers, pin cells
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Quasi mode turns on the very weak pull-up whenever the latch is 1.
// - Quasi mode turns on the weak pull-up when latch and pin are 1.
// - A quasi pin pulled low externally keeps only the very weak pull-up.
// - A quasi latch rising 0 to 1 gives a two-clock strong pull-up.
// - Quasi mode pulls the pin down whenever the latch is 0.
// - Open-drain has no pull-ups and pulls down only while latch is 0.
// - Push-pull drives strong high for latch 1 and pulls down for 0.
// - Input-only disables every driver of the pin.
// - Quasi pins act as input and output; port reads return pin level.
// - Analog disable register bits 1 to 5 cut Port 0 digital inputs from the pin-level read only, not from the weak pull-up.
// - Disabled Port 0 inputs read as 0 whatever the pin level.
// - Any reset clears analog disable bits 1 to 5.
// - After power-up every pin is input-only until software changes it.
// - Port 1 pin 5 is always an input whatever its mode bits.
// - Port 1 pins 2 and 3 never enable a pull-up.
// - Mode bits low/high per pin: 00 quasi, 01 push-pull, 10 input, 11 open-drain.
module gpc_port_ctrl (
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    // AXI4-Lite write address
    input  wire logic                  s_axi_awvalid_in,
    output logic                       s_axi_awready_out,
    input  wire logic [7:0]            s_axi_awaddr_in,
    // AXI4-Lite write data
    input  wire logic                  s_axi_wvalid_in,
    output logic                       s_axi_wready_out,
    input  wire logic [31:0]           s_axi_wdata_in,
    input  wire logic [3:0]            s_axi_wstrb_in,
    // AXI4-Lite write response
    output logic                       s_axi_bvalid_out,
    input  wire logic                  s_axi_bready_in,
    output logic [1:0]                 s_axi_bresp_out,
    // AXI4-Lite read address
    input  wire logic                  s_axi_arvalid_in,
    output logic                       s_axi_arready_out,
    input  wire logic [7:0]            s_axi_araddr_in,
    // AXI4-Lite read data
    output logic                       s_axi_rvalid_out,
    input  wire logic                  s_axi_rready_in,
    output logic [31:0]                s_axi_rdata_out,
    output logic [1:0]                 s_axi_rresp_out,
    // Pins
    input  wire logic [25:0]           pin_level_in,
    output logic [25:0]                very_weak_pu_out,
    output logic [25:0]                weak_pu_out,
    output logic [25:0]                strong_pu_out,
    output logic [25:0]                pull_down_out
);
    logic [7:0]  port_latch     [gpc_pkg::NUM_PORTS];
    logic [7:0]  port_mode_select_low  [gpc_pkg::NUM_PORTS];
    logic [7:0]  port_mode_select_high [gpc_pkg::NUM_PORTS];
    logic [7:0]  port0_analog_input_disable;
    logic [25:0] pin_meta;
    logic [25:0] pin_sync;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        wr_ok;
    logic        rd_ok;
    logic [7:0]  rd_value;
    logic [31:0] pin_word;

    // Bits that physically exist in a port; port 3 has only two pins
    function automatic logic [7:0] port_mask(input logic [1:0] port);
        return (port == 2'h3) ? gpc_pkg::PORT3_MASK : 8'hff;
    endfunction

    // Register decode, shared by the write and read paths
    function automatic logic addr_valid(input logic [7:0] addr);
        logic ok;
        ok = 1'b0;
        if (addr == gpc_pkg::ADDR_ANALOG) begin
            ok = 1'b1;
        end else if (addr[7:6] == 2'h0 && addr[1:0] == 2'h0) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    // Two-flop synchronisers; only the second stage feeds logic
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_meta <= 26'h0;
            pin_sync <= 26'h0;
        end else begin
            pin_meta <= pin_level_in;
            pin_sync <= pin_meta;
        end
    end

    // Pin level as seen by software, with analog-disabled Port 0 bits forced low
    always_comb begin
        pin_word        = {6'h0, pin_sync};
        pin_word[7:0]   = pin_sync[7:0] & ~(port0_analog_input_disable & gpc_pkg::ANALOG_MASK);
    end

    // Write address channel: hold one address until the write completes
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h0;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Write data channel, independent of the address order
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Ready is registered; it drops from the handshake until the held beat is written
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
        end else begin
            s_axi_awready_out <= !(aw_held || (s_axi_awvalid_in && s_axi_awready_out))
                                 || do_write;
            s_axi_wready_out  <= !(w_held || (s_axi_wvalid_in && s_axi_wready_out))
                                 || do_write;
        end
    end

    assign do_write = aw_held && w_held && !s_axi_bvalid_out;
    assign wr_ok    = addr_valid(aw_addr);

    // Write response is raised on the same edge as the register update
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= gpc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_ok ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // Port registers; reset leaves every pin input-only
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int p = 0; p < gpc_pkg::NUM_PORTS; p++) begin
                port_latch[p]            <= gpc_pkg::LATCH_RST;
                port_mode_select_low[p]  <= gpc_pkg::MODE_LOW_RST;
                port_mode_select_high[p] <= gpc_pkg::MODE_HIGH_RST;
            end
        end else if (do_write && w_strb[0] && aw_addr[7:6] == 2'h0) begin
            case (aw_addr[3:0])
                gpc_pkg::OFS_PIN_LEVEL,
                gpc_pkg::OFS_LATCH: begin
                    port_latch[aw_addr[5:4]] <= w_data[7:0] & port_mask(aw_addr[5:4]);
                end
                gpc_pkg::OFS_MODE_LOW: begin
                    port_mode_select_low[aw_addr[5:4]] <= w_data[7:0] & port_mask(aw_addr[5:4]);
                end
                gpc_pkg::OFS_MODE_HIGH: begin
                    port_mode_select_high[aw_addr[5:4]] <= w_data[7:0] & port_mask(aw_addr[5:4]);
                end
                default: begin
                end
            endcase
        end
    end

    // Analog input disable; only bits 1 to 5 are implemented
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            port0_analog_input_disable <= gpc_pkg::ANALOG_RST;
        end else if (do_write && w_strb[0] && aw_addr == gpc_pkg::ADDR_ANALOG) begin
            port0_analog_input_disable <= w_data[7:0] & gpc_pkg::ANALOG_MASK;
        end
    end

    // Read value decode
    always_comb begin
        rd_value = 8'h0;
        if (s_axi_araddr_in == gpc_pkg::ADDR_ANALOG) begin
            rd_value = port0_analog_input_disable;
        end else begin
            case (s_axi_araddr_in[3:0])
                gpc_pkg::OFS_PIN_LEVEL: begin
                    rd_value = pin_word[{s_axi_araddr_in[5:4], 3'h0} +: 8];
                end
                gpc_pkg::OFS_LATCH: begin
                    rd_value = port_latch[s_axi_araddr_in[5:4]];
                end
                gpc_pkg::OFS_MODE_LOW: begin
                    rd_value = port_mode_select_low[s_axi_araddr_in[5:4]];
                end
                gpc_pkg::OFS_MODE_HIGH: begin
                    rd_value = port_mode_select_high[s_axi_araddr_in[5:4]];
                end
                default: begin
                    rd_value = 8'h0;
                end
            endcase
        end
    end

    assign rd_ok = addr_valid(s_axi_araddr_in);

    // Read channel: one read at a time, data one cycle after the address
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0;
            s_axi_rresp_out   <= gpc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_ok ? {24'h0, rd_value} : 32'h0;
            s_axi_rresp_out   <= rd_ok ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end else if (!s_axi_rvalid_out) begin
            s_axi_arready_out <= 1'b1;
        end
    end

    // One control cell per pin; restricted pins are fixed by parameter
    for (genvar i = 0; i < gpc_pkg::NUM_PINS; i++) begin : g_pin
        gpc_pin_cell #(
            .FORCE_INPUT (i == gpc_pkg::PIN_RESET_INPUT),
            .NO_PULLUP   (i == gpc_pkg::PIN_CLOCK_LINE || i == gpc_pkg::PIN_DATA_LINE)
        ) u_cell (
            .clk_in           (clk_in),
            .rst_b_in         (rst_b_in),
            .latch_in         (port_latch[i / 8][i % 8]),
            .mode_in          ({port_mode_select_low[i / 8][i % 8],
                                port_mode_select_high[i / 8][i % 8]}),
            .pin_sync_in      (pin_sync[i]),
            .very_weak_pu_out (very_weak_pu_out[i]),
            .weak_pu_out      (weak_pu_out[i]),
            .strong_pu_out    (strong_pu_out[i]),
            .pull_down_out    (pull_down_out[i])
        );
    end

    a_reset_pin_input: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        1'b1 |-> !strong_pu_out[13] && !weak_pu_out[13] && !very_weak_pu_out[13]
                 && !pull_down_out[13]
    ) else $error("port 1 pin 5 is driven");

    a_bus_pins_no_pu: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        1'b1 |-> (strong_pu_out[11:10] | weak_pu_out[11:10] | very_weak_pu_out[11:10]) == 2'h0
    ) else $error("pull-up enabled on port 1 pin 2 or 3");

    a_analog_read_zero: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 8'h00
         && port0_analog_input_disable[3])
        |=> s_axi_rvalid_out && !s_axi_rdata_out[3]
    ) else $error("analog-disabled pin read as nonzero");

    a_powerup_input: assert property (
        @(posedge clk_in)
        $rose(rst_b_in) |-> port_mode_select_low[0] == 8'hff
                            && port_mode_select_high[0] == 8'h00
                            && port0_analog_input_disable == 8'h00
    ) else $error("registers not at reset value after reset");

    // Bus answers: the code follows the decode of the address that was taken
    a_write_response: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        do_write
        |=> s_axi_bvalid_out
            && s_axi_bresp_out == ($past(wr_ok) ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR)
    ) else $error("write response missing or wrong");

    a_read_answer: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (s_axi_arvalid_in && s_axi_arready_out)
        |=> s_axi_rvalid_out && !s_axi_arready_out
            && s_axi_rresp_out == ($past(rd_ok) ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR)
    ) else $error("read answer missing or wrong");
endmodule
`default_nettype wire

// ---- dv/gpc_pin_world.sv ----
// Model of the external circuits that sit on the port pins
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_world (
    input  wire logic        clk_in,
    input  wire logic [25:0] very_weak_pu_in,
    input  wire logic [25:0] weak_pu_in,
    input  wire logic [25:0] strong_pu_in,
    input  wire logic [25:0] pull_down_in,
    input  wire logic [25:0] ext_low_in,
    input  wire logic [25:0] ext_pu_in,
    output logic [25:0]      pin_level_out
);
    logic [25:0] flt = 26'h0;
    // Undriven pins wander every cycle, so a stale level never passes as valid
    always @(posedge clk_in) begin
        flt <= ~flt;
    end
    // Sinks win over pull-ups; an open-drain high needs the external resistor
    assign pin_level_out = ~pull_down_in & ~ext_low_in
        & (very_weak_pu_in | weak_pu_in | strong_pu_in | ext_pu_in | flt);
endmodule
`default_nettype wire

// ---- dv/tb_configurable_port_pin_control.sv ----
// Self-checking bench for the port pin control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_configurable_port_pin_control;
    logic        clk_in = 0;
    logic        rst_b_in = 0;
    logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0]  awa = 0, ara = 0, r;
    logic [31:0] wd = 0, rdat;
    logic        awr, wrdy, bv, arr, rv;
    logic [1:0]  bresp, rresp;
    logic [25:0] pin, vw, wk, st, pd, ext_low = 0, ext_pu = 0;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [3:0]  exp_tab [8] = '{4'h1, 4'hc, 4'h1, 4'h2, 4'h0, 4'h0, 4'h1, 4'h0};
    logic [3:0]  ws = 4'h1;
    logic [7:0]  scnt = 8'h0, s0;
    int          n_fail = 0, checked = 0, cyc = 0;

    gpc_port_ctrl u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
        .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp), .pin_level_in(pin),
        .very_weak_pu_out(vw), .weak_pu_out(wk), .strong_pu_out(st), .pull_down_out(pd));
    gpc_pin_world u_world (.clk_in(clk_in), .very_weak_pu_in(vw), .weak_pu_in(wk),
        .strong_pu_in(st), .pull_down_in(pd), .ext_low_in(ext_low), .ext_pu_in(ext_pu),
        .pin_level_out(pin));

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // Strong pull-up cycles on port 2 pin 0, sampled each edge
    always @(posedge clk_in) begin
        scnt <= scnt + {7'h0, st[16]};
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // Oldest note is matched against each completed response
    always @(posedge clk_in) begin
        if (bv && br) begin
            e = q.pop_front();
            `CHK("bresp", e, {bresp, 32'h0})
        end
        if (rv && rr) begin
            e = q.pop_front();
            `CHK("rdata", e, {rresp, rdat})
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        awv <= 1;
        wv <= 1;
        awa <= a;
        wd <= {24'h0, d};
        br <= 1;
        q.push_back({(a == 8'h40 || (a[7:6] == 2'h0 && a[1:0] == 2'h0))
                     ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR, 32'h0});
        do begin
            @(posedge clk_in);
            if (awr) awv <= 0;
            if (wrdy) wv <= 0;
        end while (!bv);
        br <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        @(posedge clk_in);
        arv <= 1;
        ara <= a;
        rr <= 1;
        q.push_back(x);
        do begin
            @(posedge clk_in);
            if (arr) arv <= 0;
        end while (!rv);
        rr <= 0;
    endtask
    // Pins settle through two sync flops plus the output register
    task automatic cp(input int i, input logic [3:0] x);
        repeat (6) @(posedge clk_in);
        `CHK("drivers", x, {vw[i], wk[i], st[i], pd[i]})
    endtask
    task automatic report_and_stop();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        void'($urandom(79));
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1;
        repeat (2) @(posedge clk_in);
        `CHK("drv_reset", 26'h0, vw | wk | st | pd)
        rd(8'h08, {2'h0, 32'hff});
        rd(8'h2c, 34'h0);
        rd(8'h40, 34'h0);
        rd(8'h50, {gpc_pkg::RESP_SLVERR, 32'h0});
        wr(8'h50, 8'h00);
        $display("test reset done");
        // Every mode with both latch values, port 2 pin 0
        for (int m = 0; m < 4; m++) begin
            wr(8'h28, {8{m[1]}});
            wr(8'h2c, {8{m[0]}});
            for (int l = 0; l < 2; l++) begin
                wr(8'h24, {7'h0, l[0]});
                cp(16, exp_tab[m*2+l]);
            end
        end
        ext_pu[16] <= 1;
        repeat (4) @(posedge clk_in);
        rd(8'h20, {2'h0, 32'h01});
        ext_pu[16] <= 0;
        $display("test modes done");
        wr(8'h28, 8'h00);
        wr(8'h2c, 8'h00);
        wr(8'h24, 8'h00);
        s0 = scnt;
        wr(8'h24, 8'h01);
        repeat (8) @(posedge clk_in);
        `CHK("strong_len", 8'h2, scnt - s0)
        ext_low[16] <= 1;
        cp(16, 4'h8);
        rd(8'h20, 34'h0);
        ext_low[16] <= 0;
        repeat (4) @(posedge clk_in);
        rd(8'h20, {2'h0, 32'h01});
        $display("test quasi done");
        wr(8'h18, 8'h00);
        wr(8'h1c, 8'h00);
        cp(10, 4'h0);
        cp(11, 4'h0);
        cp(13, 4'h0);
        cp(12, 4'hc);
        wr(8'h14, 8'h00);
        cp(10, 4'h1);
        cp(13, 4'h0);
        $display("test restricted done");
        ext_pu[7:0] <= 8'hff;
        wr(8'h40, 8'hff);
        rd(8'h40, {2'h0, 32'h3e});
        // A write with byte lane 0 off must leave the register alone
        ws <= 4'he;
        wr(8'h40, 8'h00);
        ws <= 4'h1;
        rd(8'h40, {2'h0, 32'h3e});
        repeat (4) begin
            r = 8'($urandom);
            ext_low[7:0] <= r;
            repeat (4) @(posedge clk_in);
            rd(8'h00, {26'h0, ~r & 8'hc1});
        end
        rst_b_in <= 0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1;
        repeat (2) @(posedge clk_in);
        rd(8'h40, 34'h0);
        $display("test analog done");
        report_and_stop();
    end
endmodule
`default_nettype wire
